// *** bench/uoc_ctrl_tb.sv ***
// Bench for the dual-role USB control block: registers, roles, pulses, interrupt.
// Assumes a 25 MHz clock and the bus partner model beside the block.
`timescale 1ns/1ps
`default_nettype none
module uoc_ctrl_tb;
  import uoc_pkg::*;
  logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, usb_event_i = 0;
  logic        plug_a = 0, agree = 0, id_pin, hnp_ok, t_set, t_in, t_out;
  logic [1:0]  kind = 0;
  logic [6:0]  tok_addr_i = 7'h7f;
  logic [7:0]  addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic        acc, stl, hs, lsd, rty, hm, vb, vdis, dp, dm, irq;
  int          mismatches = 0, check_count = 0;
  // 40 ns clock
  always #20 clk_i = ~clk_i;
  uoc_peer u_uoc_peer (.plug_a_i(plug_a), .agree_i(agree), .kind_i(kind), .id_pin_o(id_pin),
    .hnp_ok_o(hnp_ok), .setup_o(t_set), .in_o(t_in), .out_o(t_out));
  uoc_ctrl u_uoc_ctrl (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .id_pin_i(id_pin), .hnp_ok_i(hnp_ok), .usb_event_i, .tok_setup_i(t_set),
    .tok_in_i(t_in), .tok_out_i(t_out), .tok_addr_i, .ep_accept_o(acc), .ep_stall_o(stl),
    .ep_send_hshk_o(hs), .host_lsdir_o(lsd), .host_retry_o(rty), .host_mode_o(hm),
    .vbus_drive_o(vb), .vbus_discharge_o(vdis), .dp_pullup_o(dp), .dm_pullup_o(dm),
    .irq_o(irq));
  // Compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // Register port cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  // Endpoint enables, halt, handshake, reserved bit, unmapped place
  task automatic t_ep;
    logic [7:0] ev[6] = '{8'h08, 8'h08, 8'h04, 8'h0f, 8'h1c, 8'h0c};
    logic [1:0] kv[6] = '{2'd3, 2'd2, 2'd2, 2'd2, 2'd1, 2'd1};
    logic       ex[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    rd(ADDR_EP0_CTRL, 32'h0);
    wr(ADDR_EP0_CTRL, 32'hff);
    rd(ADDR_EP0_CTRL, 32'hdf);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_EP0_CTRL, {24'h0, ev[i]});
      kind <= kv[i];
      cyc(1);
      chkb(acc, ex[i]);
      chkb(stl, ev[i][1]);
      chkb(hs, ev[i][0]);
    end
    kind <= 2'd0;
  endtask
  // Peripheral role: no bus power, speed pull-ups, session pulses
  task automatic t_dev;
    wr(ADDR_OTG_CTRL, 32'h21);
    chkb(vb, 1'b0);
    chkb(dp, 1'b1);
    chkb(dm, 1'b0);
    chkb(hm, 1'b0);
    wr(ADDR_OTG_CTRL, 32'h30);
    chkb(dm, 1'b1);
    chkb(dp, 1'b0);
    wr(ADDR_OTG_CTRL, 32'h04);
    cyc(1);
    chkb(vb, 1'b1);
    chkb(vdis, 1'b0);
    cyc(200);
    chkb(vb, 1'b1);
    cyc(60);
    chkb(vb, 1'b0);
    chkb(vdis, 1'b1);
    wr(ADDR_OTG_CTRL, 32'h08);
    cyc(1);
    chkb(dp, 1'b1);
    cyc(260);
    chkb(dp, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h4);
  endtask
  // Enable gating, clear on read, reset of the enable register
  task automatic t_irq;
    wr(ADDR_IRQ_MASK, 32'h8);
    @(posedge clk_i);
    usb_event_i <= 1'b1;
    @(posedge clk_i);
    usb_event_i <= 1'b0;
    cyc(2);
    chkb(irq, 1'b0);
    wr(ADDR_IEC2, 32'h0200_0000);
    cyc(1);
    chkb(irq, 1'b1);
    rd(ADDR_IEC2, 32'h0200_0000);
    rd(ADDR_IRQ_STAT, 32'h8);
    cyc(1);
    chkb(irq, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_IEC2, 32'h0);
  endtask
  // Host role from plug, power, endpoint zero host bits, role swap
  task automatic t_host;
    plug_a <= 1'b1;
    cyc(3);
    chkb(hm, 1'b1);
    wr(ADDR_OTG_CTRL, 32'h01);
    chkb(vb, 1'b1);
    wr(ADDR_EP0_CTRL, 32'h80);
    chkb(lsd, 1'b1);
    chkb(rty, 1'b1);
    wr(ADDR_EP0_CTRL, 32'h40);
    chkb(lsd, 1'b0);
    chkb(rty, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h1);
    agree <= 1'b1;
    wr(ADDR_OTG_CTRL, 32'h03);
    cyc(3);
    chkb(hm, 1'b0);
    chkb(vb, 1'b1);
    rd(ADDR_IRQ_STAT, 32'h2);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_ep;
    t_dev;
    t_irq;
    t_host;
    end_of_test;
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire

// *** bench/uoc_peer.sv ***
// Far-side bus partner: plug type, token kinds and consent to a role swap.
// Assumes the bench steers it with levels changed just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module uoc_peer (
  input  wire logic       plug_a_i,
  input  wire logic       agree_i,
  input  wire logic [1:0] kind_i,
  output logic            id_pin_o,
  output logic            hnp_ok_o,
  output logic            setup_o,
  output logic            in_o,
  output logic            out_o
);
  // A micro-A plug grounds the ID pin
  assign id_pin_o = ~plug_a_i;
  // Partner end also negotiates the swap
  assign hnp_ok_o = agree_i;
  // One token kind at a time, kind 0 is idle
  assign setup_o  = (kind_i == 2'd1);
  assign in_o     = (kind_i == 2'd2);
  assign out_o    = (kind_i == 2'd3);
endmodule
`default_nettype wire

// *** logic/uoc_ctrl.sv ***
// Dual-role USB control: endpoint zero bits, interrupt enable, role and bus power.
// Assumes synchronous inputs, one clock, strobes of one cycle from the CPU side.
// How it works
// - Bit 25 of the second interrupt enable register gates the USB interrupt.
// - Every reset clears the whole second interrupt enable register.
// - The ID pin picks host role for a micro-A plug and device role for micro-B.
// - Both ends of a direct link support role swap by host negotiation.
// - An A-device sources bus power while powered, even after a swap.
// - A B-device sources bus power only during a bus power pulse, even as swapped host.
// - A B-device can request a session by bus power pulse or data-line pulse and can negotiate.
// - As peripheral the pull-up goes on D+ for full speed, on D- for low speed.
// - Only the host masters the bus and it may address up to 127 devices.
`timescale 1ns/1ps
`default_nettype none
module uoc_ctrl
  import uoc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        id_pin_i,       // High: micro-B or no plug
  input  wire logic        hnp_ok_i,       // Partner agreed to swap
  input  wire logic        usb_event_i,    // Pulse from protocol engine
  input  wire logic        tok_setup_i,    // Token kind of current packet
  input  wire logic        tok_in_i,
  input  wire logic        tok_out_i,
  input  wire logic [6:0]  tok_addr_i,
  output logic             ep_accept_o,
  output logic             ep_stall_o,
  output logic             ep_send_hshk_o,
  output logic             host_lsdir_o,
  output logic             host_retry_o,
  output logic             host_mode_o,
  output logic             vbus_drive_o,
  output logic             vbus_discharge_o,
  output logic             dp_pullup_o,
  output logic             dm_pullup_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [31:0]       rdata;
    logic [7:0]        ep0;
    logic              usb_irq_enable;
    logic [5:0]        otg;
    logic              id_prev;
    logic              a_dev;
    logic              swapped;
    uoc_srp_t          srp;
    logic [15:0]       srp_cnt;
    logic [EV_W-1:0]   stat;
    logic [EV_W-1:0]   mask;
  } uoc_state_t;

  uoc_state_t s_q;
  uoc_state_t s_d;

  logic            a_now;
  logic            host_role;
  logic [EV_W-1:0] ev;
  logic            ep_dir_ok;

  // Plug type and role resolution
  assign a_now     = ~id_pin_i;
  assign host_role = s_q.a_dev ^ s_q.swapped;

  // Endpoint direction gating
  always_comb begin
    ep_dir_ok = 1'b0;
    if (tok_setup_i) begin
      ep_dir_ok = ~(s_q.ep0[EP_CONDIS] & s_q.ep0[EP_TXEN] & s_q.ep0[EP_RXEN]);
    end else if (tok_out_i) begin
      ep_dir_ok = host_role ? s_q.ep0[EP_TXEN] : s_q.ep0[EP_RXEN];
    end else if (tok_in_i) begin
      ep_dir_ok = host_role ? s_q.ep0[EP_RXEN] : s_q.ep0[EP_TXEN];
    end
  end

  // Events from hardware
  always_comb begin
    ev              = '0;
    ev[EV_ID_CHG]   = (s_q.id_prev != a_now);
    ev[EV_ROLE]     = hnp_ok_i & s_q.otg[OC_HNP_REQ];
    ev[EV_SRP_END]  = (s_q.srp != SRP_IDLE) && (s_q.srp_cnt == 16'h0001);
    ev[EV_USB]      = usb_event_i;
  end

  // Next-state logic
  always_comb begin
    s_d       = s_q;
    s_d.id_prev = a_now;
    // Plug change ends any swap, unless a negotiated swap lands in the same cycle and toggles it
    if (ev[EV_ID_CHG]) begin
      s_d.a_dev   = a_now;
      s_d.swapped = 1'b0;
    end
    // Negotiated swap, either end may ask
    if (ev[EV_ROLE]) begin
      s_d.swapped        = ~s_q.swapped;
      s_d.otg[OC_HNP_REQ] = 1'b0;
    end
    // Session request pulse sequencer, B-device only
    case (s_q.srp)
      SRP_IDLE: begin
        if (!s_q.a_dev && s_q.otg[OC_SRP_VBUS]) begin
          s_d.srp     = SRP_VBUS;
          s_d.srp_cnt = SRP_CYC_W;
          s_d.otg[OC_SRP_VBUS] = 1'b0;
        end else if (!s_q.a_dev && s_q.otg[OC_SRP_DATA]) begin
          s_d.srp     = SRP_DATA;
          s_d.srp_cnt = SRP_CYC_W;
          s_d.otg[OC_SRP_DATA] = 1'b0;
        end else begin
          s_d.otg[OC_SRP_VBUS] = 1'b0;
          s_d.otg[OC_SRP_DATA] = 1'b0;
        end
      end
      SRP_VBUS, SRP_DATA: begin
        s_d.srp_cnt = s_q.srp_cnt - 16'h0001;
        if (s_q.srp_cnt == 16'h0001) begin
          s_d.srp = SRP_IDLE;
        end
      end
      default: s_d.srp = SRP_IDLE;
    endcase
    // Register writes
    if (wr_i) begin
      case (addr_i)
        ADDR_EP0_CTRL: s_d.ep0   = wdata_i[7:0] & EP0_WMASK;
        ADDR_IEC2:     s_d.usb_irq_enable = wdata_i[IEC_USB_IRQ_ENABLE];
        ADDR_OTG_CTRL: s_d.otg   = wdata_i[5:0];
        ADDR_IRQ_MASK: s_d.mask  = wdata_i[EV_W-1:0];
        default: ;
      endcase
    end
    // Read data, one cycle later
    s_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_EP0_CTRL: s_d.rdata = {24'h0, s_q.ep0};
        ADDR_IEC2:     s_d.rdata = 32'(s_q.usb_irq_enable) << IEC_USB_IRQ_ENABLE;
        ADDR_OTG_CTRL: s_d.rdata = {26'h0, s_q.otg};
        ADDR_OTG_STAT: s_d.rdata = {26'h0, s_q.srp, s_q.swapped, host_role, s_q.a_dev,
                                    id_pin_i};
        ADDR_IRQ_STAT: s_d.rdata = {28'h0, s_q.stat};
        ADDR_IRQ_MASK: s_d.rdata = {28'h0, s_q.mask};
        default:       s_d.rdata = '0;
      endcase
    end
    // Sticky status: read clears, a new event wins
    if (rd_i && addr_i == ADDR_IRQ_STAT) begin
      s_d.stat = ev;
    end else begin
      s_d.stat = s_q.stat | ev;
    end
    // All resets clear everything including the enable register
    if (rst_i) begin
      s_d = '0;
      s_d.a_dev   = 1'b0;
      s_d.id_prev = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // Endpoint answers
  assign ep_accept_o    = ep_dir_ok & ~s_q.ep0[EP_HALT];
  assign ep_stall_o     = s_q.ep0[EP_HALT];
  assign ep_send_hshk_o = s_q.ep0[EP_HSHK];
  // Host-only endpoint zero extras
  assign host_lsdir_o = host_role & s_q.ep0[EP_LSDIR];
  assign host_retry_o = host_role & ~s_q.ep0[EP_RETRYD];
  // Host is the sole master; device address range checked here against MAX_DEV_ADDR
  assign host_mode_o = host_role & (tok_addr_i <= 7'(MAX_DEV_ADDR));
  // Bus power: A-device keeps it while OC_VBUS_ON is set, a B-device only for its bus power pulse
  assign vbus_drive_o = (s_q.a_dev & s_q.otg[OC_VBUS_ON])
                      | (s_q.srp == SRP_VBUS);
  assign vbus_discharge_o = ~s_q.a_dev & (s_q.srp == SRP_IDLE);
  // Speed pull-ups as peripheral, D+ also pulses for data-line request
  assign dp_pullup_o = (~host_role & s_q.otg[OC_CONNECT] & ~s_q.otg[OC_LOWSPEED])
                     | (s_q.srp == SRP_DATA);
  assign dm_pullup_o = ~host_role & s_q.otg[OC_CONNECT] & s_q.otg[OC_LOWSPEED];
  assign rdata_o = s_q.rdata;
  // Interrupt level gated by the USB enable
  assign irq_o = s_q.usb_irq_enable & |(s_q.stat & s_q.mask);

  // Checks
  sequence srp_start_s;
    !s_q.a_dev && s_q.srp == SRP_IDLE && s_q.otg[OC_SRP_VBUS] && !rst_i;
  endsequence
  sequence srp_vbus_s;
    vbus_drive_o [*8];
  endsequence

  a_usb_irq_enable_gates_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.usb_irq_enable |-> !irq_o) else $error("irq with enable clear");
  a_reset_clears_ie: assert property (@(posedge clk_i)
    rst_i |=> (!s_q.usb_irq_enable && !irq_o)) else $error("enable kept over reset");
  a_id_sets_role: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(a_now) |=> ##1 (s_q.a_dev == $past(a_now, 2) && !s_q.swapped))
    else $error("role not from plug");
  a_hnp_swaps_role: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_ROLE] && !ev[EV_ID_CHG] |=> host_role != $past(host_role))
    else $error("swap missed");
  a_bdev_no_vbus: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s_q.a_dev && s_q.srp != SRP_VBUS) |-> !vbus_drive_o) else $error("B drives bus");
  a_adev_keeps_vbus: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.a_dev && s_q.otg[OC_VBUS_ON]) |-> vbus_drive_o) else $error("A lost power");
  a_srp_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i)
    srp_start_s |=> srp_vbus_s) else $error("short power pulse");
  a_pullup_speed: assert property (@(posedge clk_i) disable iff (rst_i)
    !(dp_pullup_o && dm_pullup_o)) else $error("both pull-ups on");
  a_stall_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.ep0[EP_HALT] |-> (ep_stall_o && !ep_accept_o)) else $error("stall ignored");
  a_retry_host_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !host_role |-> (!host_lsdir_o && !host_retry_o)) else $error("host bit in device");
  a_host_only_master: assert property (@(posedge clk_i) disable iff (rst_i)
    host_mode_o |-> host_role) else $error("device mastering");

endmodule
`default_nettype wire

// *** pkg/uoc_pkg.sv ***
// Package for the dual-role USB control block: register map, field positions, states.
// Assumes a plain register port with one-cycle strobes and 32-bit data.
package uoc_pkg;

  // Register word offsets (byte addresses)
  localparam logic [7:0] ADDR_EP0_CTRL = 8'h00;  // endpoint_zero_control
  localparam logic [7:0] ADDR_IEC2     = 8'h04;  // interrupt_enable_second
  localparam logic [7:0] ADDR_OTG_CTRL = 8'h08;  // Role and power control
  localparam logic [7:0] ADDR_OTG_STAT = 8'h0c;  // Role state, read only
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;  // Sticky events, clear on read
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;  // Event mask

  // Endpoint zero control fields
  localparam int EP_HSHK    = 0;
  localparam int EP_HALT    = 1;
  localparam int EP_TXEN    = 2;
  localparam int EP_RXEN    = 3;
  localparam int EP_CONDIS  = 4;
  localparam int EP_RETRYD  = 6;
  localparam int EP_LSDIR   = 7;
  localparam logic [7:0] EP0_WMASK = 8'hdf;  // Bit 5 reserved

  // Interrupt enable field
  localparam int IEC_USB_IRQ_ENABLE = 25;

  // Role control fields
  localparam int OC_VBUS_ON  = 0;  // Firmware request to power bus
  localparam int OC_HNP_REQ  = 1;  // Request role swap
  localparam int OC_SRP_VBUS = 2;  // Start bus power pulse
  localparam int OC_SRP_DATA = 3;  // Start data-line pulse
  localparam int OC_LOWSPEED = 4;  // Peripheral announces low speed
  localparam int OC_CONNECT  = 5;  // Peripheral pull-up enable

  // Event bits
  localparam int EV_ID_CHG  = 0;
  localparam int EV_ROLE    = 1;
  localparam int EV_SRP_END = 2;
  localparam int EV_USB     = 3;
  localparam int EV_W       = 4;

  // Pulse timing
  localparam int  CLK_HZ       = 25_000_000;
  localparam int  SRP_PULSE_US = 10;
  localparam int  SRP_CYC      = (SRP_PULSE_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] SRP_CYC_W = 16'(SRP_CYC);

  localparam int MAX_DEV_ADDR = 127;

  typedef enum logic [1:0] {
    SRP_IDLE = 2'b00,
    SRP_VBUS = 2'b01,
    SRP_DATA = 2'b10
  } uoc_srp_t;

endpackage
